// *** uart_modem_ctrl_baud_gen_bench.sv ***
`timescale 1ns/10ps
module uart_modem_ctrl_baud_gen_bench import umc_pkg::*;;
    localparam logic [7:0] DIV5 = 8'(100000000 / (16 * 1250000));
    logic aclk, aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid;
    logic s_axi_rready, rx_pin, tx_shift_reg_out, rx_int, tx_int, auto_rts_level_n;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic cts_n, dsr_n, ri_n, dcd_n, dtr_n, rts_n, user_output_1_n, aux_output_pin_n;
    logic tx_pin, rx_shift_in, auto_cts_enable, auto_rts_enable, cts_active;
    logic irq_out, irq_oe, baud_tick_16x;
    logic [7:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb, want;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    int mismatches = 0;
    int checks_done = 0;
    int i, c;
    umc_modem_ctrl uut (.*);
    umc_modem_model modem (.*);
    // 100 MHz clock
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic finish_test();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    task automatic hang();
        mismatches++;
        finish_test();
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge aclk);
    endtask
    // each channel is dropped at the edge that takes it; one idle edge keeps drivers clean
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] er);
        int n;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h000000, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (n = 0; n < 99; n++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid) break;
        end
        if (n == 99) hang();
        chk(s_axi_bresp, er);
        s_axi_bready <= 1'b0;
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] ex, input logic [7:0] m,
                      input logic [1:0] er);
        int n;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (n = 0; n < 99; n++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid) break;
        end
        if (n == 99) hang();
        chk(s_axi_rdata & {24'hFFFFFF, m}, {24'h000000, ex});
        chk(s_axi_rresp, er);
        s_axi_rready <= 1'b0;
        @(posedge aclk);
    endtask
    // cycles between two ticks; the stretch from a reload to the first tick is skipped
    task automatic period(input int exp);
        for (c = 0; c < 999 && baud_tick_16x !== 1'b1; c++) @(posedge aclk);
        for (c = 1; c < 999; c++) begin
            @(posedge aclk);
            if (baud_tick_16x === 1'b1) break;
        end
        chk(c, exp);
    endtask
    // main sequence
    initial begin
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h00;
        {ce, rx_pin, auto_rts_level_n, tx_shift_reg_out, rx_int, tx_int} = 6'h38;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
        s_axi_wstrb = 4'hF;
        want = 4'h0;
        cyc(12);
        aresetn <= 1'b1;
        chk({aux_output_pin_n, user_output_1_n, rts_n, dtr_n, irq_oe}, 5'h1E);
        rd(ADDR_MODEM_STATUS, 8'h00, 8'hFF, RESP_OKAY);
        for (i = 0; i < 4; i++) begin
            wr(ADDR_MODEM_CONTROL, 8'h01 << i, RESP_OKAY);
            rd(ADDR_MODEM_CONTROL, 8'h01 << i, 8'hFF, RESP_OKAY);
            chk({aux_output_pin_n, user_output_1_n, rts_n, dtr_n, auto_cts_enable,
                 auto_rts_enable}, {4'hF ^ (4'h1 << i), 2'b00});
            chk(irq_oe, i == 3);
        end
        want <= 4'hB;
        cyc(6);
        rd(ADDR_MODEM_STATUS, 8'hBB, 8'hFF, RESP_OKAY);
        rd(ADDR_MODEM_STATUS, 8'hB0, 8'hFF, RESP_OKAY);
        want <= 4'hF;
        cyc(6);
        rd(ADDR_MODEM_STATUS, 8'hF0, 8'hFF, RESP_OKAY);
        want <= 4'hB;
        cyc(6);
        rd(ADDR_MODEM_STATUS, 8'hB4, 8'hFF, RESP_OKAY);
        wr(ADDR_INT_ENABLE, 8'h08, RESP_OKAY);
        chk(irq_out, 1'b0);
        want <= 4'h9;
        cyc(6);
        chk(irq_out, 1'b1);
        rd(ADDR_INT_STATUS, 8'h01, 8'h01, RESP_OKAY);
        rd(ADDR_MODEM_STATUS, 8'h92, 8'hFF, RESP_OKAY);
        chk(irq_out, 1'b0);
        want <= 4'h1;
        cyc(6);
        chk(irq_out, 1'b1);
        rd(ADDR_MODEM_STATUS, 8'h18, 8'hFF, RESP_OKAY);
        wr(ADDR_MODEM_CONTROL, 8'h28, RESP_OKAY);
        chk({auto_cts_enable, auto_rts_enable}, 2'b10);
        want <= 4'h0;
        cyc(6);
        chk(irq_out, 1'b0);
        rd(ADDR_MODEM_STATUS, 8'h00, 8'hF0, RESP_OKAY);
        wr(ADDR_MODEM_CONTROL, 8'h2A, RESP_OKAY);
        auto_rts_level_n <= 1'b0;
        cyc(1);
        chk({auto_cts_enable, auto_rts_enable, rts_n}, 3'b110);
        auto_rts_level_n <= 1'b1;
        wr(ADDR_MODEM_CONTROL, 8'h1F, RESP_OKAY);
        chk({aux_output_pin_n, user_output_1_n, rts_n, dtr_n, cts_active}, 5'h1F);
        tx_shift_reg_out <= 1'b1;
        rx_pin <= 1'b0;
        cyc(3);
        chk({tx_pin, rx_shift_in}, 2'b11);
        tx_shift_reg_out <= 1'b0;
        cyc(3);
        chk({tx_pin, rx_shift_in}, 2'b10);
        rd(ADDR_MODEM_STATUS, 8'hF0, 8'hF0, RESP_OKAY);
        wr(ADDR_MODEM_CONTROL, 8'h11, RESP_OKAY);
        rd(ADDR_MODEM_STATUS, 8'h20, 8'hF0, RESP_OKAY);
        wr(ADDR_MODEM_CONTROL, 8'h18, RESP_OKAY);
        chk(irq_out, 1'b1);
        rd(ADDR_MODEM_STATUS, 8'h8A, 8'hFF, RESP_OKAY);
        rx_int <= 1'b1;
        cyc(1);
        chk(irq_out, 1'b1);
        rd(ADDR_INT_STATUS, 8'h02, 8'h07, RESP_OKAY);
        {rx_int, tx_int} <= 2'b01;
        cyc(1);
        chk(irq_out, 1'b1);
        {tx_int, tx_shift_reg_out} <= 2'b01;
        wr(ADDR_MODEM_CONTROL, 8'h00, RESP_OKAY);
        chk({tx_pin, rx_shift_in}, 2'b10);
        wr(ADDR_LINE_CONTROL, 8'h80, RESP_OKAY);
        wr(ADDR_DIV_LOW, DIV5, RESP_OKAY);
        wr(ADDR_DIV_HIGH, 8'h00, RESP_OKAY);
        period(DIV5);
        wr(ADDR_DIV_HIGH, 8'h01, RESP_OKAY);
        period(256 + DIV5);
        wr(ADDR_DIV_HIGH, 8'h00, RESP_OKAY);
        for (c = 1; c < 999; c++) begin
            @(posedge aclk);
            if (baud_tick_16x === 1'b1) break;
        end
        chk(c, DIV5);
        rd(ADDR_INT_ENABLE, 8'h00, 8'hFF, RESP_SLVERR);
        wr(ADDR_LINE_CONTROL, 8'h00, RESP_OKAY);
        wr(ADDR_DIV_LOW, 8'h01, RESP_SLVERR);
        rd(ADDR_INT_ENABLE, 8'h08, 8'hFF, RESP_OKAY);
        rd(8'h40, 8'h00, 8'hFF, RESP_SLVERR);
        finish_test();
    end
endmodule

// *** umc_baud_gen.sv ***
`timescale 1ns/10ps
// down counter producing the 16x bit-rate enable
module umc_baud_gen
    import umc_pkg::*;
#(
    parameter int DIV_W = 16
) (
    input wire logic aclk, // system clock
    input wire logic aresetn, // synchronous reset, active low
    input wire logic ce, // clock enable
    input wire logic [DIV_W-1:0] divisor, // programmed divisor
    input wire logic reload, // latch write, restart count
    output logic tick_16x // one-cycle 16x enable
);
    logic [DIV_W-1:0] count;
    logic [DIV_W-1:0] next_count;
    logic next_tick;

    // divisor of zero behaves as one so the enable never stalls
    always_comb begin
        next_count = count;
        next_tick = 1'b0;
        if (reload) begin
            next_count = divisor;
        end else if (count <= DIV_W'(1)) begin
            next_tick = 1'b1;
            next_count = divisor;
        end else begin
            next_count = count - DIV_W'(1);
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count <= DIV_W'(DIVISOR_RST);
            tick_16x <= 1'b0;
        end else if (ce) begin
            count <= next_count;
            tick_16x <= next_tick;
        end
    end
endmodule

// *** umc_modem_ctrl.sv ***
`timescale 1ns/10ps
// Functional notes
// - modem_control bit 0 drives the data-terminal-ready output directly
// - modem_control bit 1 drives request-to-send unless auto rts owns it
// - bit 2 is user output 1, fed to ring input in loopback
// - bit 3 enables interrupt driver; aux output pin is its inverse
// - loopback holds tx high, ignores rx, loops shift output to receiver
// - loopback disconnects modem inputs, outputs high, routes bits inward
// - loopback keeps interrupts; modem sources become low four control bits
// - autoflow bit 5 with rts picks auto rts+cts, cts only, or none
// - change flags set on input change, all cleared by status read
// - cts change flag interrupts only when enabled and autoflow is off
// - dsr change flag raises modem interrupt when enabled
// - ring flag sets on ring input low-to-high, interrupts when enabled
// - carrier change flag raises modem interrupt when enabled
// - status bits 4..7 return complemented cts, dsr, ri, dcd
// - in loopback status 4..7 equal rts, dtr, user_output_1, user_output_2
// - baud generator divides by 1..65535, output sixteen times bit rate
// - divisor in two byte latches; writing either reloads the counter
// - line control bit 7 selects divisor latches over interrupt_enable
module umc_modem_ctrl
    import umc_pkg::*;
(
    input wire logic aclk, // system clock, 100 MHz
    input wire logic aresetn, // synchronous reset, active low
    input wire logic ce, // clock enable, freezes all state
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write byte strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [7:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic cts_n, // clear to send pin, active low
    input wire logic dsr_n, // data set ready pin, active low
    input wire logic ri_n, // ring indicator pin, active low
    input wire logic dcd_n, // carrier detect pin, active low
    output logic dtr_n, // data terminal ready pin, active low
    output logic rts_n, // request to send pin, active low
    output logic user_output_1_n, // user output 1 pin, active low
    output logic aux_output_pin_n, // aux output pin, low when user_output_2 set outside loopback
    input wire logic rx_pin, // serial receive pin
    output logic tx_pin, // serial transmit pin
    input wire logic tx_shift_reg_out, // transmitter shift register output
    output logic rx_shift_in, // serial input to receiver shift register
    input wire logic rx_int, // receive interrupt request from receiver
    input wire logic tx_int, // transmit interrupt request from transmitter
    input wire logic auto_rts_level_n, // rts level asked by receive fifo
    output logic auto_cts_enable, // transmitter waits on cts when high
    output logic auto_rts_enable, // rts pin follows receive fifo when high
    output logic cts_active, // effective cts seen by the transmitter
    output logic irq_out, // interrupt level
    output logic irq_oe, // interrupt pin driver enable
    output logic baud_tick_16x // one-cycle 16x baud enable
);
    logic [7:0] modem_control, next_modem_control;
    logic [7:0] line_control, next_line_control;
    logic [7:0] interrupt_enable, next_interrupt_enable;
    logic [15:0] divisor, next_divisor;
    logic div_reload, next_div_reload;
    logic [3:0] change_flags, next_change_flags;
    logic [3:0] sync1, sync2, prev_level; // order: cts, dsr, ri, dcd (asserted = 1)
    logic [3:0] next_prev_level;
    logic rx_sync1, rx_sync2;
    logic aw_held, w_held, next_aw_held, next_w_held;
    logic [7:0] aw_addr, next_aw_addr;
    logic [31:0] w_data, next_w_data;
    logic [3:0] w_strb, next_w_strb;
    logic bvalid, next_bvalid;
    logic [1:0] bresp, next_bresp;
    logic rvalid, next_rvalid;
    logic [1:0] rresp, next_rresp;
    logic [31:0] rdata, next_rdata;
    logic [3:0] level_now;
    logic loop_on;
    logic status_read;
    logic [7:0] status_value;
    logic msi_pending;
    logic do_write;

    // true when an address hits a divisor latch under the access select
    function automatic logic is_div(input logic [7:0] a, input logic [7:0] lc);
        return lc[LC_DIV_SEL] && (a == ADDR_DIV_LOW || a == ADDR_DIV_HIGH);
    endfunction

    // true for any mapped address under the current access select
    function automatic logic is_mapped(input logic [7:0] a, input logic [7:0] lc);
        logic hit;
        hit = (a == ADDR_MODEM_CONTROL) || (a == ADDR_MODEM_STATUS) ||
              (a == ADDR_LINE_CONTROL) || (a == ADDR_INT_STATUS);
        if (a == ADDR_INT_ENABLE) begin
            hit = !lc[LC_DIV_SEL];
        end
        if (a == ADDR_DIV_LOW || a == ADDR_DIV_HIGH) begin
            hit = is_div(a, lc);
        end
        return hit;
    endfunction

    assign loop_on = modem_control[MC_LOOP];

    // modem inputs seen internally, true means asserted
    always_comb begin
        if (loop_on) begin
            level_now = {modem_control[MC_RTS], modem_control[MC_DTR],
                         modem_control[MC_USER_OUTPUT_1], modem_control[MC_USER_OUTPUT_2]};
        end else begin
            level_now = sync2;
        end
    end

    // modem_status read value: delta flags low, asserted levels high
    assign status_value = {level_now[0], level_now[1], level_now[2], level_now[3],
                           change_flags};

    // pin side outputs, all forced inactive high in loopback; rx_shift_in takes tx_shift_reg_out instead
    assign dtr_n = loop_on ? 1'b1 : ~modem_control[MC_DTR];
    assign rts_n = loop_on ? 1'b1 :
                   (auto_rts_enable ? auto_rts_level_n : ~modem_control[MC_RTS]);
    assign user_output_1_n = loop_on ? 1'b1 : ~modem_control[MC_USER_OUTPUT_1];
    assign aux_output_pin_n = loop_on ? 1'b1 : ~modem_control[MC_USER_OUTPUT_2];
    assign tx_pin = loop_on ? 1'b1 : tx_shift_reg_out;
    assign rx_shift_in = loop_on ? tx_shift_reg_out : rx_sync2;

    // flow configuration
    assign auto_cts_enable = modem_control[MC_AFE];
    assign auto_rts_enable = modem_control[MC_AFE] & modem_control[MC_RTS];
    assign cts_active = level_now[3];

    // modem status interrupt; cts change silent while autoflow is on
    assign msi_pending = interrupt_enable[IE_MODEM] &
        ((change_flags[MS_DCTS] & ~modem_control[MC_AFE]) |
         change_flags[MS_DDSR] | change_flags[MS_RING_TRAILING_EDGE_FLAG] | change_flags[MS_DDCD]);
    assign irq_out = (msi_pending | rx_int | tx_int) & modem_control[MC_USER_OUTPUT_2];
    assign irq_oe = modem_control[MC_USER_OUTPUT_2];

    // handshake outputs are combinational, data outputs registered;
    // ce low hides every ready and valid so no beat is lost while state is frozen
    assign s_axi_awready = ce && !aw_held && !bvalid;
    assign s_axi_wready = ce && !w_held && !bvalid;
    assign s_axi_arready = ce && !rvalid;
    assign s_axi_bvalid = ce && bvalid;
    assign s_axi_bresp = bresp;
    assign s_axi_rvalid = ce && rvalid;
    assign s_axi_rresp = rresp;
    assign s_axi_rdata = rdata;

    assign do_write = aw_held && w_held && !bvalid;
    assign status_read = s_axi_arvalid && s_axi_arready && (s_axi_araddr == ADDR_MODEM_STATUS);

    // bus slave next state: capture aw and w in either order, answer after both
    always_comb begin
        next_aw_held = aw_held;
        next_w_held = w_held;
        next_aw_addr = aw_addr;
        next_w_data = w_data;
        next_w_strb = w_strb;
        next_bvalid = bvalid;
        next_bresp = bresp;
        next_rvalid = rvalid;
        next_rresp = rresp;
        next_rdata = rdata;
        next_modem_control = modem_control;
        next_line_control = line_control;
        next_interrupt_enable = interrupt_enable;
        next_divisor = divisor;
        next_div_reload = 1'b0;
        if (s_axi_awvalid && s_axi_awready) begin
            next_aw_held = 1'b1;
            next_aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            next_w_held = 1'b1;
            next_w_data = s_axi_wdata;
            next_w_strb = s_axi_wstrb;
        end
        if (do_write) begin
            next_aw_held = 1'b0;
            next_w_held = 1'b0;
            next_bvalid = 1'b1;
            next_bresp = is_mapped(aw_addr, line_control) ? RESP_OKAY : RESP_SLVERR;
            if (w_strb[0]) begin
                case (aw_addr)
                    ADDR_MODEM_CONTROL: next_modem_control = {2'h0, w_data[5:0]};
                    ADDR_LINE_CONTROL: next_line_control = w_data[7:0];
                    ADDR_INT_ENABLE: begin
                        if (!line_control[LC_DIV_SEL]) begin
                            next_interrupt_enable = {4'h0, w_data[3:0]};
                        end
                    end
                    ADDR_DIV_LOW: begin
                        if (is_div(aw_addr, line_control)) begin
                            next_divisor[7:0] = w_data[7:0];
                            next_div_reload = 1'b1;
                        end
                    end
                    ADDR_DIV_HIGH: begin
                        if (is_div(aw_addr, line_control)) begin
                            next_divisor[15:8] = w_data[7:0];
                            next_div_reload = 1'b1;
                        end
                    end
                    default: ;
                endcase
            end
        end
        if (bvalid && s_axi_bready) begin
            next_bvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            next_rvalid = 1'b1;
            next_rresp = is_mapped(s_axi_araddr, line_control) ? RESP_OKAY : RESP_SLVERR;
            case (s_axi_araddr)
                ADDR_MODEM_CONTROL: next_rdata = {24'h000000, modem_control};
                ADDR_MODEM_STATUS: next_rdata = {24'h000000, status_value};
                ADDR_LINE_CONTROL: next_rdata = {24'h000000, line_control};
                ADDR_INT_ENABLE: next_rdata = line_control[LC_DIV_SEL] ? 32'h00000000 :
                                              {24'h000000, interrupt_enable};
                ADDR_DIV_LOW: next_rdata = is_div(s_axi_araddr, line_control) ?
                                           {24'h000000, divisor[7:0]} : 32'h00000000;
                ADDR_DIV_HIGH: next_rdata = is_div(s_axi_araddr, line_control) ?
                                            {24'h000000, divisor[15:8]} : 32'h00000000;
                ADDR_INT_STATUS: next_rdata = {29'h00000000, tx_int, rx_int, msi_pending};
                default: next_rdata = 32'h00000000;
            endcase
        end else if (rvalid && s_axi_rready) begin
            next_rvalid = 1'b0;
        end
    end

    // change detection: a new edge wins over a clear from the same read
    always_comb begin
        next_prev_level = level_now;
        next_change_flags = status_read ? 4'h0 : change_flags;
        if (level_now[3] != prev_level[3]) begin
            next_change_flags[MS_DCTS] = 1'b1;
        end
        if (level_now[2] != prev_level[2]) begin
            next_change_flags[MS_DDSR] = 1'b1;
        end
        // ring pin low-to-high means asserted goes to deasserted
        if (prev_level[1] && !level_now[1]) begin
            next_change_flags[MS_RING_TRAILING_EDGE_FLAG] = 1'b1;
        end
        if (level_now[0] != prev_level[0]) begin
            next_change_flags[MS_DDCD] = 1'b1;
        end
    end

    // two-stage synchronisers for all pin inputs; first stage feeds only the second
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
            rx_sync1 <= 1'b1;
            rx_sync2 <= 1'b1;
        end else if (ce) begin
            sync1 <= {~cts_n, ~dsr_n, ~ri_n, ~dcd_n};
            sync2 <= sync1;
            rx_sync1 <= rx_pin;
            rx_sync2 <= rx_sync1;
        end
    end

    // register all state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            modem_control <= MODEM_CONTROL_RST;
            line_control <= LINE_CONTROL_RST;
            interrupt_enable <= INT_ENABLE_RST;
            divisor <= DIVISOR_RST;
            div_reload <= 1'b0;
            change_flags <= 4'h0;
            prev_level <= 4'h0;
            aw_held <= 1'b0;
            w_held <= 1'b0;
            aw_addr <= 8'h00;
            w_data <= 32'h00000000;
            w_strb <= 4'h0;
            bvalid <= 1'b0;
            bresp <= RESP_OKAY;
            rvalid <= 1'b0;
            rresp <= RESP_OKAY;
            rdata <= 32'h00000000;
        end else if (ce) begin
            modem_control <= next_modem_control;
            line_control <= next_line_control;
            interrupt_enable <= next_interrupt_enable;
            divisor <= next_divisor;
            div_reload <= next_div_reload;
            change_flags <= next_change_flags;
            prev_level <= next_prev_level;
            aw_held <= next_aw_held;
            w_held <= next_w_held;
            aw_addr <= next_aw_addr;
            w_data <= next_w_data;
            w_strb <= next_w_strb;
            bvalid <= next_bvalid;
            bresp <= next_bresp;
            rvalid <= next_rvalid;
            rresp <= next_rresp;
            rdata <= next_rdata;
        end
    end

    // baud generator restarts from the new divisor after a latch write
    umc_baud_gen #(
        .DIV_W(16)
    ) u_baud (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .divisor(divisor),
        .reload(div_reload),
        .tick_16x(baud_tick_16x)
    );
endmodule

// *** umc_modem_ctrl_assertions.sv ***
`timescale 1ns/10ps
// checks the modem pins against a shadow copy of modem_control
module umc_modem_ctrl_assertions
    import umc_pkg::*;
(
    input wire logic aclk, // clock
    input wire logic aresetn, // sync reset, active low
    input wire logic [7:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // aw valid
    input wire logic s_axi_awready, // aw ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // w valid
    input wire logic s_axi_bvalid, // b valid
    input wire logic dtr_n, // dtr pin
    input wire logic rts_n, // rts pin
    input wire logic user_output_1_n, // user_output_1 pin
    input wire logic aux_output_pin_n, // aux pin
    input wire logic tx_pin, // serial out
    input wire logic tx_shift_reg_out, // shift register out
    input wire logic rx_shift_in, // receiver input
    input wire logic auto_cts_enable, // auto cts
    input wire logic auto_rts_enable, // auto rts
    input wire logic irq_out, // irq level
    input wire logic irq_oe // irq driver enable
);
    default clocking @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    logic [7:0] mc;
    logic [7:0] next_mc;
    logic lp;
    logic arts;
    // shadow runs one edge ahead of the register, so checks wait for awready
    always_comb begin
        next_mc = mc;
        if (!aresetn) begin
            next_mc = MODEM_CONTROL_RST;
        end else if (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wstrb[0]
                     && s_axi_awaddr == ADDR_MODEM_CONTROL) begin
            next_mc = {2'h0, s_axi_wdata[5:0]}; // bits 7:6 are not stored
        end
    end
    always_ff @(posedge aclk) begin
        mc <= next_mc;
    end
    assign lp = mc[MC_LOOP];
    assign arts = mc[MC_AFE] && mc[MC_RTS];
    sequence s_wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid;
    endsequence
    sequence s_wr_answer;
        !s_axi_bvalid ##1 s_axi_bvalid;
    endsequence
    a_dtr_level: assert property (s_axi_awready |-> dtr_n == (lp || !mc[MC_DTR]))
        else $error("dtr pin disagrees with control");
    a_rts_level: assert property (s_axi_awready && !arts |-> rts_n == (lp || !mc[MC_RTS]))
        else $error("rts pin disagrees with control");
    a_user_output_1_level: assert property (s_axi_awready |-> user_output_1_n == (lp || !mc[MC_USER_OUTPUT_1]))
        else $error("user output pin disagrees with control");
    a_aux_gate: assert property (s_axi_awready |-> aux_output_pin_n == (lp || !mc[MC_USER_OUTPUT_2])
        && irq_oe == mc[MC_USER_OUTPUT_2]) else $error("aux pin or irq enable wrong");
    a_irq_quiet: assert property (s_axi_awready && !mc[MC_USER_OUTPUT_2] |-> !irq_out)
        else $error("irq level while driver is off");
    a_loop_path: assert property (s_axi_awready |-> tx_pin == (lp || tx_shift_reg_out)
        && (!lp || rx_shift_in == tx_shift_reg_out)) else $error("loop data path wrong");
    a_flow_mode: assert property (s_axi_awready |-> auto_cts_enable == mc[MC_AFE]
        && auto_rts_enable == arts) else $error("flow mode decode wrong");
    a_write_answer: assert property (s_wr_take |-> ##1 s_wr_answer)
        else $error("write response not two edges after take");
endmodule
bind umc_modem_ctrl umc_modem_ctrl_assertions chk (.*);

// *** umc_modem_model.sv ***
`timescale 1ns/10ps
// far-end data set: drives the four status lines, active low
module umc_modem_model (
    input wire logic aclk, // clock, unused by this simple set
    input wire logic [3:0] want, // asserted lines: dcd ri dsr cts
    output logic cts_n, // clear to send
    output logic dsr_n, // data set ready
    output logic ri_n, // ring indicator
    output logic dcd_n // carrier detect
);
    // the bench moves want just after an edge, so lines never change on the sampling edge
    assign {dcd_n, ri_n, dsr_n, cts_n} = ~want;
endmodule

// *** umc_pkg.sv ***
package umc_pkg;
    // register byte addresses on the axi4-lite bus
    localparam logic [7:0] ADDR_MODEM_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_MODEM_STATUS = 8'h04;
    localparam logic [7:0] ADDR_LINE_CONTROL = 8'h08;
    localparam logic [7:0] ADDR_INT_ENABLE = 8'h0C;
    localparam logic [7:0] ADDR_DIV_LOW = 8'h10;
    localparam logic [7:0] ADDR_DIV_HIGH = 8'h14;
    localparam logic [7:0] ADDR_INT_STATUS = 8'h18;
    // modem_control fields
    localparam int MC_DTR = 0;
    localparam int MC_RTS = 1;
    localparam int MC_USER_OUTPUT_1 = 2;
    localparam int MC_USER_OUTPUT_2 = 3;
    localparam int MC_LOOP = 4;
    localparam int MC_AFE = 5;
    // modem_status fields
    localparam int MS_DCTS = 0;
    localparam int MS_DDSR = 1;
    localparam int MS_RING_TRAILING_EDGE_FLAG = 2;
    localparam int MS_DDCD = 3;
    // line_control divisor access select
    localparam int LC_DIV_SEL = 7;
    // interrupt_enable modem status enable
    localparam int IE_MODEM = 3;
    // reset values
    localparam logic [7:0] MODEM_CONTROL_RST = 8'h00;
    localparam logic [7:0] LINE_CONTROL_RST = 8'h00;
    localparam logic [7:0] INT_ENABLE_RST = 8'h00;
    localparam logic [15:0] DIVISOR_RST = 16'h0001;
    localparam int BAUD_OVERSAMPLE = 16;
    // axi response codes
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage
